// >>> rtl/ssrb_pkg.sv
package ssrb_pkg;

  localparam int unsigned SSRB_REG_W        = 16;
  localparam int unsigned SSRB_ADDR_W       = 16;
  localparam int unsigned SSRB_CNT_W        = 7;
  localparam int unsigned SSRB_FLAG_W       = 8;
  localparam int unsigned SSRB_NUM_REGS     = 10;
  localparam int unsigned SSRB_IDX_W        = 4;

  // frame addresses (register number minus one)
  localparam logic [15:0] SSRB_ADDR_ALT_STATE  = 16'h03ec;
  localparam logic [15:0] SSRB_ADDR_NORM_VALID = 16'h03ed;
  localparam logic [15:0] SSRB_ADDR_NORM_COND  = 16'h03ee;
  localparam logic [15:0] SSRB_ADDR_ALT_VALID  = 16'h03ef;
  localparam logic [15:0] SSRB_ADDR_ALT_COND   = 16'h03f0;
  localparam logic [15:0] SSRB_ADDR_SHED_CAP   = 16'h03fc;
  localparam logic [15:0] SSRB_ADDR_SHED_STATE = 16'h03fd;
  localparam logic [15:0] SSRB_ADDR_GEN_CAP    = 16'h03fe;
  localparam logic [15:0] SSRB_ADDR_GEN_STATE  = 16'h03ff;
  localparam logic [15:0] SSRB_ADDR_RUN_MODE   = 16'h044b;

  // contiguous mapped blocks, bounds inclusive
  localparam logic [16:0] SSRB_BLK0_LO = 17'h003ec;
  localparam logic [16:0] SSRB_BLK0_HI = 17'h003f0;
  localparam logic [16:0] SSRB_BLK1_LO = 17'h003fc;
  localparam logic [16:0] SSRB_BLK1_HI = 17'h003ff;
  localparam logic [16:0] SSRB_BLK2_LO = 17'h0044b;
  localparam logic [16:0] SSRB_BLK2_HI = 17'h0044b;

  // snapshot slots
  localparam logic [3:0] SSRB_IDX_ALT_STATE  = 4'h0;
  localparam logic [3:0] SSRB_IDX_NORM_VALID = 4'h1;
  localparam logic [3:0] SSRB_IDX_NORM_COND  = 4'h2;
  localparam logic [3:0] SSRB_IDX_ALT_VALID  = 4'h3;
  localparam logic [3:0] SSRB_IDX_ALT_COND   = 4'h4;
  localparam logic [3:0] SSRB_IDX_SHED_CAP   = 4'h5;
  localparam logic [3:0] SSRB_IDX_SHED_STATE = 4'h6;
  localparam logic [3:0] SSRB_IDX_GEN_CAP    = 4'h7;
  localparam logic [3:0] SSRB_IDX_GEN_STATE  = 4'h8;
  localparam logic [3:0] SSRB_IDX_RUN_MODE   = 4'h9;

  // condition bit positions, shared by validity and status words
  localparam int unsigned SSRB_BIT_PHASE_SEQ  = 0;
  localparam int unsigned SSRB_BIT_NEUT_POS   = 1;
  localparam int unsigned SSRB_BIT_UNBALANCE  = 2;
  localparam int unsigned SSRB_BIT_NEUT_LOSS  = 3;
  localparam int unsigned SSRB_BIT_OVER_VOLT  = 4;
  localparam int unsigned SSRB_BIT_UNDER_VOLT = 5;
  localparam int unsigned SSRB_BIT_OVER_FREQ  = 6;
  localparam int unsigned SSRB_BIT_UNDER_FREQ = 7;

  // pole variant codes and the condition bits each one carries
  localparam logic [1:0] SSRB_POLE_TWO   = 2'h0;
  localparam logic [1:0] SSRB_POLE_THREE = 2'h1;
  localparam logic [1:0] SSRB_POLE_FOUR  = 2'h2;
  localparam logic [7:0] SSRB_MASK_FOUR_POLE_VARIANT  = 8'hff;
  localparam logic [7:0] SSRB_MASK_THREE_OR_FOUR_POLE = 8'hf4;
  localparam logic [7:0] SSRB_MASK_ANY_POLE           = 8'hf0;

  // read transaction limits and exception codes
  localparam logic [6:0] SSRB_MAX_READ_COUNT   = 7'h7d;
  localparam logic [7:0] SSRB_EXC_NONE         = 8'h00;
  localparam logic [7:0] SSRB_EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] SSRB_EXC_ILLEGAL_VAL  = 8'h03;

  localparam logic [15:0] SSRB_RESET_WORD = 16'h0000;

  typedef enum logic [2:0] {
    SSRB_S_IDLE = 3'b001,
    SSRB_S_SEND = 3'b010,
    SSRB_S_REST = 3'b100
  } ssrb_state_t;

endpackage

// >>> rtl/ssrb_cond_word.sv
`timescale 1ns/10ps
`default_nettype none

// builds the validity and status words of one source for the installed pole variant
module ssrb_cond_word (
  input  wire logic [1:0]  poleVariant,
  input  wire logic [7:0]  flagValid,
  input  wire logic [7:0]  flagPresent,
  output logic      [15:0] validWord,
  output logic      [15:0] condWord
);
  import ssrb_pkg::*;

  logic [7:0] applicable;

  always_comb begin
    unique case (poleVariant)
      SSRB_POLE_FOUR:  applicable = SSRB_MASK_FOUR_POLE_VARIANT;
      SSRB_POLE_THREE: applicable = SSRB_MASK_THREE_OR_FOUR_POLE;
      // two-pole and unknown codes fall back to the bits every variant has
      default:         applicable = SSRB_MASK_ANY_POLE;
    endcase
  end

  // upper byte and non-applicable bits read zero
  assign validWord = {8'h00, flagValid & applicable};
  assign condWord  = {8'h00, flagPresent & applicable};

endmodule

`default_nettype wire

// >>> rtl/ssrb_source_status_bank.sv
// What this block does
// - alternate state reads 0 range,1 out,2 none
// - normal validity word, bits 0-7, 1=valid
// - normal status word, bit set while condition present
// - alternate validity word mirrors normal validity layout
// - alternate status word mirrors normal status layout
// - bits 0,1,3 four-pole; 2 three/four; 4-7 all
// - load-shed capability and active status words
// - generator-control capability word reads 1 when supported
// - generator state 0 inactive,1 active,2 unable
// - runtime mode 0 init to 5 local
// - 16-bit registers; frame address is number minus one
// - unimplemented address answers illegal data address exception
`timescale 1ns/10ps
`default_nettype none

module ssrb_source_status_bank (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  // read request from the frame engine
  input  wire logic                        reqValid,
  input  wire logic [ssrb_pkg::SSRB_ADDR_W-1:0] reqStart,
  input  wire logic [ssrb_pkg::SSRB_CNT_W-1:0]  reqCount,
  output logic                             reqReady,
  // answer words, one per cycle
  output logic                             wordValid,
  output logic [ssrb_pkg::SSRB_REG_W-1:0]  wordData,
  output logic                             wordLast,
  // exception answer
  output logic                             excValid,
  output logic [7:0]                       excCode,
  // live device state, same clock domain
  input  wire logic [1:0]                  poleVariant,
  input  wire logic [1:0]                  altSourceState,
  input  wire logic [ssrb_pkg::SSRB_FLAG_W-1:0] normFlagValid,
  input  wire logic [ssrb_pkg::SSRB_FLAG_W-1:0] normFlagPresent,
  input  wire logic [ssrb_pkg::SSRB_FLAG_W-1:0] altFlagValid,
  input  wire logic [ssrb_pkg::SSRB_FLAG_W-1:0] altFlagPresent,
  input  wire logic                        loadShedSupported,
  input  wire logic                        loadShedActive,
  input  wire logic                        genCtrlSupported,
  input  wire logic [1:0]                  genCtrlState,
  input  wire logic [2:0]                  runMode
);
  import ssrb_pkg::*;

  typedef struct packed {
    ssrb_state_t                                st;
    logic [SSRB_ADDR_W-1:0]                     addr;
    logic [SSRB_CNT_W-1:0]                      left;
    logic [SSRB_NUM_REGS-1:0][SSRB_REG_W-1:0]   snap;
    logic                                       reqReady;
    logic                                       wordValid;
    logic [SSRB_REG_W-1:0]                      wordData;
    logic                                       wordLast;
    logic                                       excValid;
    logic [7:0]                                 excCode;
  } ssrb_regs_t;

  localparam ssrb_regs_t SSRB_REGS_RESET = '{
    st:        SSRB_S_IDLE,
    addr:      '0,
    left:      '0,
    snap:      '0,
    reqReady:  1'b0,
    wordValid: 1'b0,
    wordData:  SSRB_RESET_WORD,
    wordLast:  1'b0,
    excValid:  1'b0,
    excCode:   SSRB_EXC_NONE
  };

  ssrb_regs_t r;
  ssrb_regs_t next_r;

  logic [1:0][SSRB_REG_W-1:0] srcValidWord;
  logic [1:0][SSRB_REG_W-1:0] srcCondWord;
  logic [1:0][SSRB_FLAG_W-1:0] srcFlagValid;
  logic [1:0][SSRB_FLAG_W-1:0] srcFlagPresent;
  logic [SSRB_NUM_REGS-1:0][SSRB_REG_W-1:0] live;

  assign srcFlagValid[0]   = normFlagValid;
  assign srcFlagPresent[0] = normFlagPresent;
  assign srcFlagValid[1]   = altFlagValid;
  assign srcFlagPresent[1] = altFlagPresent;

  // one condition packer per source
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_src
      ssrb_cond_word u_cond (
        .poleVariant (poleVariant),
        .flagValid   (srcFlagValid[gi]),
        .flagPresent (srcFlagPresent[gi]),
        .validWord   (srcValidWord[gi]),
        .condWord    (srcCondWord[gi])
      );
    end
  endgenerate

  // live register images, narrow fields zero-extended to 16 bits
  always_comb begin
    live                      = '0;
    live[SSRB_IDX_ALT_STATE]  = {14'h0000, altSourceState};
    live[SSRB_IDX_NORM_VALID] = srcValidWord[0];
    live[SSRB_IDX_NORM_COND]  = srcCondWord[0];
    live[SSRB_IDX_ALT_VALID]  = srcValidWord[1];
    live[SSRB_IDX_ALT_COND]   = srcCondWord[1];
    live[SSRB_IDX_SHED_CAP]   = {15'h0000, loadShedSupported};
    live[SSRB_IDX_SHED_STATE] = {15'h0000, loadShedActive};
    live[SSRB_IDX_GEN_CAP]    = {15'h0000, genCtrlSupported};
    live[SSRB_IDX_GEN_STATE]  = {14'h0000, genCtrlState};
    live[SSRB_IDX_RUN_MODE]   = {13'h0000, runMode};
  end

  // frame address to snapshot slot
  function automatic logic [SSRB_IDX_W-1:0] slotOf(input logic [SSRB_ADDR_W-1:0] a);
    logic [SSRB_IDX_W-1:0] s;
    s = SSRB_IDX_ALT_STATE;
    unique case (a)
      SSRB_ADDR_ALT_STATE:  s = SSRB_IDX_ALT_STATE;
      SSRB_ADDR_NORM_VALID: s = SSRB_IDX_NORM_VALID;
      SSRB_ADDR_NORM_COND:  s = SSRB_IDX_NORM_COND;
      SSRB_ADDR_ALT_VALID:  s = SSRB_IDX_ALT_VALID;
      SSRB_ADDR_ALT_COND:   s = SSRB_IDX_ALT_COND;
      SSRB_ADDR_SHED_CAP:   s = SSRB_IDX_SHED_CAP;
      SSRB_ADDR_SHED_STATE: s = SSRB_IDX_SHED_STATE;
      SSRB_ADDR_GEN_CAP:    s = SSRB_IDX_GEN_CAP;
      SSRB_ADDR_GEN_STATE:  s = SSRB_IDX_GEN_STATE;
      SSRB_ADDR_RUN_MODE:   s = SSRB_IDX_RUN_MODE;
      default:              s = SSRB_IDX_ALT_STATE;
    endcase
    return s;
  endfunction

  // request range checks
  logic [16:0] reqFirst;
  logic [16:0] reqEnd;
  logic        countBad;
  logic        rangeHit;

  assign reqFirst = {1'b0, reqStart};
  assign reqEnd   = reqFirst + {10'h000, reqCount} - 17'h00001;
  assign countBad = (reqCount == '0) || (reqCount > SSRB_MAX_READ_COUNT);

  // whole range must sit inside one implemented block
  always_comb begin
    rangeHit = 1'b0;
    if ((reqFirst >= SSRB_BLK0_LO) && (reqEnd <= SSRB_BLK0_HI)) begin
      rangeHit = 1'b1;
    end
    if ((reqFirst >= SSRB_BLK1_LO) && (reqEnd <= SSRB_BLK1_HI)) begin
      rangeHit = 1'b1;
    end
    if ((reqFirst >= SSRB_BLK2_LO) && (reqEnd <= SSRB_BLK2_HI)) begin
      rangeHit = 1'b1;
    end
  end

  always_comb begin
    next_r           = r;
    next_r.wordValid = 1'b0;
    next_r.wordLast  = 1'b0;
    next_r.excValid  = 1'b0;
    unique case (r.st)
      SSRB_S_IDLE: begin
        next_r.reqReady = 1'b1;
        if (reqValid && r.reqReady) begin
          next_r.reqReady = 1'b0;
          next_r.addr     = reqStart;
          next_r.left     = reqCount;
          // snapshot keeps all words of one answer coherent
          next_r.snap     = live;
          if (countBad) begin
            next_r.excValid = 1'b1;
            next_r.excCode  = SSRB_EXC_ILLEGAL_VAL;
            next_r.st       = SSRB_S_REST;
          end else if (!rangeHit) begin
            next_r.excValid = 1'b1;
            next_r.excCode  = SSRB_EXC_ILLEGAL_ADDR;
            next_r.st       = SSRB_S_REST;
          end else begin
            next_r.excCode  = SSRB_EXC_NONE;
            next_r.st       = SSRB_S_SEND;
          end
        end
      end
      SSRB_S_SEND: begin
        next_r.wordValid = 1'b1;
        next_r.wordData  = r.snap[slotOf(r.addr)];
        next_r.wordLast  = (r.left == 7'h01);
        next_r.addr      = r.addr + 16'h0001;
        next_r.left      = r.left - 7'h01;
        if (r.left == 7'h01) begin
          next_r.st = SSRB_S_REST;
        end
      end
      SSRB_S_REST: begin
        next_r.reqReady = 1'b1;
        next_r.st       = SSRB_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= SSRB_REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign reqReady  = r.reqReady;
  assign wordValid = r.wordValid;
  assign wordData  = r.wordData;
  assign wordLast  = r.wordLast;
  assign excValid  = r.excValid;
  assign excCode   = r.excCode;

endmodule

`default_nettype wire

// >>> bench/ssrb_client_model.sv
`timescale 1ns/10ps
`default_nettype none

// field-bus client side: one read request at a time, collects the answer
module ssrb_client_model (
  input  wire logic        clk,
  output logic             reqValid,
  output logic [15:0]      reqStart,
  output logic [6:0]       reqCount,
  input  wire logic        reqReady,
  input  wire logic        wordValid,
  input  wire logic [15:0] wordData,
  input  wire logic        wordLast,
  input  wire logic        excValid,
  input  wire logic [7:0]  excCode
);
  logic [15:0] words[$];
  logic [7:0]  gotCode;
  initial begin
    reqValid = 1'b0;
    reqStart = 16'h0000;
    reqCount = 7'h00;
  end
  // start is the frame address, register number minus one
  task automatic read(input logic [15:0] start, input logic [6:0] cnt);
    int n;
    words.delete();
    gotCode = 8'h00;
    reqStart = start;
    reqCount = cnt;
    reqValid = 1'b1;
    // ready is read between edges, where it is settled; the request is
    // taken at the first edge that follows a cycle with ready high
    for (n = 0; n < 200 && reqReady !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 reqValid = 1'b0;
    // released qualifiers do not keep the old value
    reqStart = ~start;
    reqCount = ~cnt;
    // answer outputs are looked at just after the edge that launched them
    for (n = 0; n < 200; n++) begin
      if (wordValid === 1'b1) words.push_back(wordData);
      if (excValid === 1'b1) gotCode = excCode;
      if (wordLast === 1'b1 || excValid === 1'b1) break;
      @(posedge clk);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/ssrb_source_status_bank_properties.sv
`timescale 1ns/10ps
`default_nettype none

module ssrb_source_status_bank_properties
  import ssrb_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        reqValid,
  input wire logic [15:0] reqStart,
  input wire logic [6:0]  reqCount,
  input wire logic        reqReady,
  input wire logic        wordValid,
  input wire logic [15:0] wordData,
  input wire logic        wordLast,
  input wire logic        excValid,
  input wire logic [7:0]  excCode,
  input wire logic [2:0]  runMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  function automatic logic inMap(logic [15:0] a);
    return (17'(a) >= SSRB_BLK0_LO && 17'(a) <= SSRB_BLK0_HI) ||
           (17'(a) >= SSRB_BLK1_LO && 17'(a) <= SSRB_BLK1_HI) || 17'(a) == SSRB_BLK2_LO;
  endfunction
  a_ready_drop: assert property (reqValid && reqReady |=> !reqReady)
    else $error("ready stayed high after accept");
  a_answer_kind: assert property (reqValid && reqReady |=>
    (excValid ##1 reqReady) or (!excValid ##1 wordValid)) else $error("bad answer timing");
  a_exc_code: assert property (excValid |-> excCode == SSRB_EXC_ILLEGAL_ADDR ||
    excCode == SSRB_EXC_ILLEGAL_VAL) else $error("bad exception code");
  a_bad_count: assert property (reqValid && reqReady && (reqCount == 7'h00 ||
    reqCount > 7'h7d) |=> excValid && excCode == 8'h03) else $error("count not refused");
  a_unmapped_one: assert property (reqValid && reqReady && reqCount == 7'h01 &&
    !inMap(reqStart) |=> excValid && excCode == 8'h02) else $error("unmapped not refused");
  a_single_word: assert property (reqValid && reqReady && reqCount == 7'h01 &&
    inMap(reqStart) |-> ##2 wordValid && wordLast) else $error("single word missing");
  a_no_exc_words: assert property (excValid |-> !wordValid)
    else $error("words with exception");
  a_last_valid: assert property (wordLast |-> wordValid)
    else $error("last without valid");
  a_ready_busy: assert property (wordValid |-> !reqReady)
    else $error("ready during answer");
  a_mode_word: assert property (reqValid && reqReady && reqStart == SSRB_ADDR_RUN_MODE &&
    reqCount == 7'h01 |-> ##2 wordData == {13'h0000, $past(runMode, 2)}) else $error("mode word");
  c_last: cover property (wordLast);
  c_addr: cover property (excValid && excCode == 8'h02);
  c_count: cover property (excValid && excCode == 8'h03);
endmodule

bind ssrb_source_status_bank ssrb_source_status_bank_properties chk (.clk(clk), .rstn(rstn),
  .reqValid(reqValid), .reqStart(reqStart), .reqCount(reqCount), .reqReady(reqReady),
  .wordValid(wordValid), .wordData(wordData), .wordLast(wordLast), .excValid(excValid),
  .excCode(excCode), .runMode(runMode));
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import ssrb_pkg::*;
  logic        clk, rstn, loadShedSupported, loadShedActive, genCtrlSupported;
  logic [1:0]  poleVariant, altSourceState, genCtrlState;
  logic [7:0]  normFlagValid, normFlagPresent, altFlagValid, altFlagPresent, m;
  logic [2:0]  runMode;
  wire logic   reqValid, reqReady, wordValid, wordLast, excValid;
  wire logic [15:0] reqStart, wordData;
  wire logic [6:0]  reqCount;
  wire logic [7:0]  excCode;
  int          miscompares, samples_checked;
  logic [15:0] eS[6] = '{16'h03f1, 16'h03eb, 16'h03fc, 16'h03ec, 16'h03ec, 16'h03ec};
  logic [6:0]  eC[6] = '{7'h01, 7'h02, 7'h05, 7'h7d, 7'h00, 7'h7e};
  logic [7:0]  eX[6] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h03, 8'h03};

  ssrb_source_status_bank uut (.clk(clk), .rstn(rstn), .reqValid(reqValid),
    .reqStart(reqStart), .reqCount(reqCount), .reqReady(reqReady), .wordValid(wordValid),
    .wordData(wordData), .wordLast(wordLast), .excValid(excValid), .excCode(excCode),
    .poleVariant(poleVariant), .altSourceState(altSourceState), .normFlagValid(normFlagValid),
    .normFlagPresent(normFlagPresent), .altFlagValid(altFlagValid),
    .altFlagPresent(altFlagPresent), .loadShedSupported(loadShedSupported),
    .loadShedActive(loadShedActive), .genCtrlSupported(genCtrlSupported),
    .genCtrlState(genCtrlState), .runMode(runMode));
  ssrb_client_model cl (.clk(clk), .reqValid(reqValid), .reqStart(reqStart),
    .reqCount(reqCount), .reqReady(reqReady), .wordValid(wordValid), .wordData(wordData),
    .wordLast(wordLast), .excValid(excValid), .excCode(excCode));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t code %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #300000;
    miscompares++;
    summarize();
  end
  initial begin
    rstn = 1'b0;
    {poleVariant, altSourceState, genCtrlState, runMode} = '0;
    {normFlagValid, normFlagPresent, altFlagValid, altFlagPresent} = '0;
    {loadShedSupported, loadShedActive, genCtrlSupported} = '0;
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    #1;
    for (int p = 0; p < 4; p++) begin
      poleVariant = 2'(p);
      altSourceState = 2'(p % 3);
      normFlagValid = 8'h5a ^ 8'(p);
      normFlagPresent = 8'hff - 8'(p);
      altFlagValid = 8'hff;
      altFlagPresent = 8'ha5 ^ 8'(p << 1);
      m = (p == 2) ? 8'hff : (p == 1) ? 8'hf4 : 8'hf0;
      cl.read(16'h03ec, 7'h05);
      chk16(16'(cl.words.size()), 16'h0005);
      chk16(cl.words[0], {14'h0000, altSourceState});
      chk16(cl.words[1], {8'h00, normFlagValid & m});
      chk16(cl.words[2], {8'h00, normFlagPresent & m});
      chk16(cl.words[3], {8'h00, altFlagValid & m});
      chk16(cl.words[4], {8'h00, altFlagPresent & m});
      $display("source words test %0d done", p);
    end
    for (int g = 0; g < 3; g++) begin
      // every capability and state bit is seen both low and high
      {loadShedSupported, loadShedActive, genCtrlSupported} = 3'(g + 3);
      genCtrlState = 2'(g);
      cl.read(16'h03fc, 7'h04);
      chk16(cl.words[0], {15'h0000, loadShedSupported});
      chk16(cl.words[1], {15'h0000, loadShedActive});
      chk16(cl.words[2], {15'h0000, genCtrlSupported});
      chk16(cl.words[3], {14'h0000, genCtrlState});
      $display("shed and generator test %0d done", g);
    end
    for (int r = 0; r < 6; r++) begin
      runMode = 3'(r);
      cl.read(16'h044b, 7'h01);
      chk16(cl.words[0], {13'h0000, runMode});
    end
    $display("mode test done");
    for (int i = 0; i < 6; i++) begin
      cl.read(eS[i], eC[i]);
      chk8(cl.gotCode, eX[i]);
      chk16(16'(cl.words.size()), 16'h0000);
    end
    $display("refusal test done");
    // reset in mid-run clears the standing answer registers
    rstn = 1'b0;
    #1;
    chk8(excCode, 8'h00);
    chk16(wordData, 16'h0000);
    chk8({7'h00, reqReady}, 8'h00);
    @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    #1;
    cl.read(16'h03ec, 7'h01);
    chk16(16'(cl.words.size()), 16'h0001);
    chk16(cl.words[0], {14'h0000, altSourceState});
    $display("reset test done");
    summarize();
  end
endmodule
`default_nettype wire
